// File: shared/lcca_map.vh
// Constants for the logic, compare and call execution block
`ifndef LCCA_MAP_VH
`define LCCA_MAP_VH
// Register file locations of the stack pointer
`define LCCA_SP_HIGH_ADDR 8'hFE
`define LCCA_SP_LOW_ADDR 8'hFF
// Working register escape nibble
`define LCCA_WORK_NIBBLE 4'hE
// Opcodes (high nibble selects the operation)
`define LCCA_HI_AND 4'h5
`define LCCA_HI_ADD 4'h0
`define LCCA_HI_CMP 4'hA
`define LCCA_OP_INV_DIR 8'h60
`define LCCA_OP_INV_IND 8'h61
`define LCCA_OP_ZF_DIR 8'hB0
`define LCCA_OP_ZF_IND 8'hB1
`define LCCA_OP_FLIP_C 8'hEF
`define LCCA_OP_CALL_DIR 8'hD6
`define LCCA_OP_CALL_IND 8'hD4
// Cycle counts
`define LCCA_CYC_PACKED 5'd6
`define LCCA_CYC_FULL 5'd10
`define LCCA_CYC_FLIP 5'd6
`define LCCA_CYC_ONE_OP 5'd6
`define LCCA_CYC_CALL 5'd20
// Flag bit positions in the flag register
`define LCCA_FL_C 7
`define LCCA_FL_Z 6
`define LCCA_FL_S 5
`define LCCA_FL_V 4
`define LCCA_FL_D 3
`define LCCA_FL_H 2
// APB offsets (byte addresses)
`define LCCA_A_CTRL 12'h000
`define LCCA_A_OPC 12'h004
`define LCCA_A_OPA 12'h008
`define LCCA_A_OPB 12'h00C
`define LCCA_A_PCIN 12'h010
`define LCCA_A_FLAGS 12'h014
`define LCCA_A_STATUS 12'h018
`define LCCA_A_PC 12'h01C
`define LCCA_A_EXTCFG 12'h020
`define LCCA_A_RF_BASE 12'h400
`define LCCA_A_XM_BASE 12'h800
`define LCCA_PSLVERR_UNMAPPED 1'b1
`endif

// File: src/lcca_core.v
// Execution unit for AND, add, invert, zero-fill, compare, carry flip and call
//
// Operation
// [RL1] AND stores the bitwise AND of destination and source in the destination, opcodes 52 to 57.
// [RL2] AND sets zero and sign from the result, clears overflow, keeps carry, decimal-adjust and half-carry.
// [RL3] A full-register operand byte with high nibble 1110B names working register low-nibble.
// [RL4] Add writes the two's complement sum of destination and source to the destination.
// [RL5] Add sets carry, half-carry, overflow, zero and sign from the sum and clears decimal-adjust.
// [RL6] Two-register forms take source byte then destination byte, 10 cycles; packed forms take 6.
// [RL7] Call lowers the stack pointer by two, pushes the return address, loads the target, keeps flags.
// [RL8] The stack pointer lives at FEH/FFH; 16-bit pushes go to external memory, 8-bit to the register file.
// [RL9] Call takes a direct 16-bit target (D6) or an indirect register-pair target (D4).
// [RL10] Carry flip (EF, 6 cycles) inverts carry and keeps every other flag.
// [RL11] Zero-fill writes 00H to the destination, direct (B0) or indirect (B1), without touching flags.
// [RL12] Invert (60/61) writes the one's complement, sets zero and sign, clears overflow.
// [RL13] Compare (A2 to A7) subtracts source from destination for flags only, writing nothing back.
// [RL14] Compare sets carry on borrow, zero, sign and overflow from the difference, keeps D and H.
// [RL15] An indirect operand first reads the named register and uses its content as the operand address.
`timescale 1ns/1ps
`default_nettype none
`include "lcca_map.vh"
module lcca_core #(
    parameter XMEM_AW = 8
) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire busy,
    output reg done_q
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    reg [1:0] st_q;
    reg [4:0] cyc_q;
    reg [7:0] rf [0:255];
    reg [7:0] xm [0:(1<<XMEM_AW)-1];
    reg [7:0] opc_q, opa_q, opb_q, flags_q, rp_q;
    reg [15:0] pc_in_q, pc_q;
    reg sp16_q, bad_q;
    wire wr_acc = psel && penable && pwrite && st_q == ST_IDLE;
    wire rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign busy = (st_q == ST_RUN);
    wire rf_hit = paddr[11:10] == 2'b01;
    wire xm_hit = paddr[11:10] == 2'b10 && paddr[9:2] < (1 << XMEM_AW);
    wire reg_hit = paddr == `LCCA_A_CTRL || paddr == `LCCA_A_OPC || paddr == `LCCA_A_OPA
        || paddr == `LCCA_A_OPB || paddr == `LCCA_A_PCIN || paddr == `LCCA_A_FLAGS
        || paddr == `LCCA_A_STATUS || paddr == `LCCA_A_PC || paddr == `LCCA_A_EXTCFG;
    assign pslverr = psel && penable && !(rf_hit || xm_hit || reg_hit) ? `LCCA_PSLVERR_UNMAPPED : 1'b0;

    // ------------------------------------------------------------
    // Operand addressing
    // ------------------------------------------------------------
    function [7:0] eff;
        input [7:0] b;
        input [7:0] rp;
        // [RL3] working register escape
        eff = (b[7:4] == `LCCA_WORK_NIBBLE) ? {rp[7:4], b[3:0]} : b;
    endfunction
    wire [3:0] lo = opc_q[3:0];
    wire [3:0] hi = opc_q[7:4];
    wire is_alu = hi == `LCCA_HI_AND || hi == `LCCA_HI_ADD || hi == `LCCA_HI_CMP;
    // [RL6] packed form: dst in high nibble, src in low nibble
    wire [7:0] pk_dst = {rp_q[7:4], opa_q[7:4]};
    wire [7:0] pk_src = {rp_q[7:4], opa_q[3:0]};
    // [RL6] two-register form: src byte first, dst byte second
    wire [7:0] fr_src = eff(opa_q, rp_q);
    wire [7:0] fr_dst = eff(opb_q, rp_q);
    wire [7:0] imm_dst = eff(opa_q, rp_q);
    reg [7:0] dst_a, src_v;
    always @*
    begin
        dst_a = imm_dst;
        src_v = opb_q;
        case (lo)
            4'h2:
            begin
                dst_a = pk_dst;
                src_v = rf[pk_src];
            end
            4'h3:
            begin
                dst_a = pk_dst;
                // [RL15] indirect through the register
                src_v = rf[rf[pk_src]];
            end
            4'h4:
            begin
                dst_a = fr_dst;
                src_v = rf[fr_src];
            end
            4'h5:
            begin
                dst_a = fr_dst;
                src_v = rf[rf[fr_src]];
            end
            4'h6:
            begin
                dst_a = imm_dst;
                src_v = opb_q;
            end
            4'h7:
            begin
                // [RL15] indirect destination
                dst_a = rf[imm_dst];
                src_v = opb_q;
            end
            default:
            begin
                dst_a = imm_dst;
                src_v = opb_q;
            end
        endcase
    end
    // One-operand forms: even opcode direct, odd indirect
    wire [7:0] one_a = opc_q[0] ? rf[imm_dst] : imm_dst;
    wire [7:0] dv = rf[dst_a];
    wire [7:0] ov = rf[one_a];

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    wire [8:0] sum = {1'b0, dv} + {1'b0, src_v};
    wire [4:0] hsum = {1'b0, dv[3:0]} + {1'b0, src_v[3:0]};
    wire [8:0] diff = {1'b0, dv} + {1'b0, ~src_v} + 9'h001;
    wire [7:0] andv = dv & src_v;
    wire [7:0] invv = ~ov;
    // Call target and return address
    wire [7:0] tp_a = eff(opa_q, rp_q);
    wire [15:0] tgt = (opc_q == `LCCA_OP_CALL_DIR) ? {opa_q, opb_q} : {rf[tp_a], rf[tp_a + 8'h01]};
    wire [15:0] ret_pc = pc_in_q + ((opc_q == `LCCA_OP_CALL_DIR) ? 16'h0003 : 16'h0002);
    wire [15:0] sp_old = {sp16_q ? rf[`LCCA_SP_HIGH_ADDR] : 8'h00, rf[`LCCA_SP_LOW_ADDR]};
    wire [15:0] sp_new = sp_old - 16'h0002;
    wire legal = is_alu && lo >= 4'h2 && lo <= 4'h7 || opc_q == `LCCA_OP_INV_DIR || opc_q == `LCCA_OP_INV_IND
        || opc_q == `LCCA_OP_ZF_DIR || opc_q == `LCCA_OP_ZF_IND || opc_q == `LCCA_OP_FLIP_C
        || opc_q == `LCCA_OP_CALL_DIR || opc_q == `LCCA_OP_CALL_IND;
    wire [4:0] cyc_need = (opc_q == `LCCA_OP_FLIP_C) ? `LCCA_CYC_FLIP :
        (opc_q[7:4] == 4'hD) ? `LCCA_CYC_CALL :
        (is_alu && lo < 4'h4) ? `LCCA_CYC_PACKED :
        is_alu ? `LCCA_CYC_FULL : `LCCA_CYC_ONE_OP;

    // ------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        done_q <= 1'b0;
        if (rst)
        begin
            st_q <= ST_IDLE;
            cyc_q <= 5'd0;
            opc_q <= 8'h00;
            opa_q <= 8'h00;
            opb_q <= 8'h00;
            flags_q <= 8'h00;
            rp_q <= 8'h00;
            pc_in_q <= 16'h0000;
            pc_q <= 16'h0000;
            sp16_q <= 1'b0;
            bad_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (wr_acc)
                    begin
                        case (paddr)
                            `LCCA_A_CTRL:
                            if (pwdata[0])
                            begin
                                st_q <= ST_RUN;
                                cyc_q <= 5'd1;
                                bad_q <= 1'b0;
                            end
                            `LCCA_A_OPC: opc_q <= pwdata[7:0];
                            `LCCA_A_OPA: opa_q <= pwdata[7:0];
                            `LCCA_A_OPB: opb_q <= pwdata[7:0];
                            `LCCA_A_PCIN: pc_in_q <= pwdata[15:0];
                            `LCCA_A_FLAGS: flags_q <= pwdata[7:0];
                            `LCCA_A_EXTCFG:
                            begin
                                sp16_q <= pwdata[0];
                                rp_q <= {pwdata[11:8], 4'h0};
                            end
                            default: ;
                        endcase
                        if (rf_hit)
                            rf[paddr[9:2]] <= pwdata[7:0];
                        if (xm_hit)
                            xm[paddr[XMEM_AW+1:2]] <= pwdata[7:0];
                    end
                end
                ST_RUN:
                begin
                    // Work lands in the last cycle so cycle counts are exact
                    if (cyc_q < cyc_need && legal)
                        cyc_q <= cyc_q + 5'd1;
                    else
                    begin
                        st_q <= ST_IDLE;
                        done_q <= 1'b1;
                        if (!legal)
                            bad_q <= 1'b1;
                        else if (hi == `LCCA_HI_AND)
                        begin
                            // [RL1] AND result to destination
                            rf[dst_a] <= andv;
                            // [RL2] AND flags
                            flags_q[`LCCA_FL_Z] <= andv == 8'h00;
                            flags_q[`LCCA_FL_S] <= andv[7];
                            flags_q[`LCCA_FL_V] <= 1'b0;
                        end
                        else if (hi == `LCCA_HI_ADD)
                        begin
                            // [RL4] sum to destination
                            rf[dst_a] <= sum[7:0];
                            // [RL5] add flags
                            flags_q[`LCCA_FL_C] <= sum[8];
                            flags_q[`LCCA_FL_Z] <= sum[7:0] == 8'h00;
                            flags_q[`LCCA_FL_S] <= sum[7];
                            flags_q[`LCCA_FL_V] <= (dv[7] == src_v[7]) && (sum[7] != dv[7]);
                            flags_q[`LCCA_FL_D] <= 1'b0;
                            flags_q[`LCCA_FL_H] <= hsum[4];
                        end
                        else if (hi == `LCCA_HI_CMP)
                        begin
                            // [RL13] flags only, no write back
                            // [RL14] borrow is inverted carry out
                            flags_q[`LCCA_FL_C] <= ~diff[8];
                            flags_q[`LCCA_FL_Z] <= diff[7:0] == 8'h00;
                            flags_q[`LCCA_FL_S] <= diff[7];
                            flags_q[`LCCA_FL_V] <= (dv[7] != src_v[7]) && (diff[7] != dv[7]);
                        end
                        else if (opc_q[7:1] == 7'h30)
                        begin
                            // [RL12] one's complement
                            rf[one_a] <= invv;
                            flags_q[`LCCA_FL_Z] <= invv == 8'h00;
                            flags_q[`LCCA_FL_S] <= invv[7];
                            flags_q[`LCCA_FL_V] <= 1'b0;
                        end
                        else if (opc_q[7:1] == 7'h58)
                            // [RL11] zero fill, flags kept
                            rf[one_a] <= 8'h00;
                        else if (opc_q == `LCCA_OP_FLIP_C)
                            // [RL10] carry flip
                            flags_q[`LCCA_FL_C] <= ~flags_q[`LCCA_FL_C];
                        else
                        begin
                            // [RL7] push return address, load target; [RL9] both target forms
                            pc_q <= tgt;
                            rf[`LCCA_SP_LOW_ADDR] <= sp_new[7:0];
                            // [RL8] 16-bit pointer pushes to external memory
                            if (sp16_q)
                            begin
                                rf[`LCCA_SP_HIGH_ADDR] <= sp_new[15:8];
                                xm[sp_new[XMEM_AW-1:0]] <= ret_pc[15:8];
                                xm[sp_new[XMEM_AW-1:0] + 1'b1] <= ret_pc[7:0];
                            end
                            else
                            begin
                                rf[sp_new[7:0]] <= ret_pc[15:8];
                                rf[sp_new[7:0] + 8'h01] <= ret_pc[7:0];
                            end
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            if (rf_hit)
                prdata <= {24'h00_0000, rf[paddr[9:2]]};
            else if (xm_hit)
                prdata <= {24'h00_0000, xm[paddr[XMEM_AW+1:2]]};
            else
                case (paddr)
                    `LCCA_A_OPC: prdata <= {24'h00_0000, opc_q};
                    `LCCA_A_OPA: prdata <= {24'h00_0000, opa_q};
                    `LCCA_A_OPB: prdata <= {24'h00_0000, opb_q};
                    `LCCA_A_PCIN: prdata <= {16'h0000, pc_in_q};
                    `LCCA_A_FLAGS: prdata <= {24'h00_0000, flags_q};
                    `LCCA_A_STATUS: prdata <= {30'h0000_0000, bad_q, busy};
                    `LCCA_A_PC: prdata <= {16'h0000, pc_q};
                    `LCCA_A_EXTCFG: prdata <= {20'h0_0000, rp_q[7:4], 7'h00, sp16_q};
                    default: prdata <= 32'h0000_0000;
                endcase
        end
    end
    wire unused_ok = rd_acc;
endmodule // lcca_core
`default_nettype wire

// File: tb/lcca_checker_assertions.sv
// Port-level assertion checker for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "lcca_map.vh"
module lcca_checker (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire busy,
    input wire done_q
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [7:0] opc_q;
    logic [5:0] run_len_q;
    always @(posedge ref_clk)
        run_len_q <= (rst || !busy) ? 6'd0 : run_len_q + 6'd1;
    // Opcode seen at the port, the body is hidden
    always @(posedge ref_clk)
        if (psel && penable && pwrite && paddr == `LCCA_A_OPC)
            opc_q <= pwdata[7:0];
    function automatic logic [5:0] exp_len(input logic [7:0] op);
        if (op == 8'hD4 || op == 8'hD6)
            exp_len = 6'd20;
        else if (op == 8'hEF || op[7:1] == 7'h30 || op[7:1] == 7'h58)
            exp_len = 6'd6;
        else if ((op[7:4] == 4'h0 || op[7:4] == 4'h5 || op[7:4] == 4'hA) && op[3:0] >= 4'h2 && op[3:0] <= 4'h7)
            exp_len = op[2] ? 6'd10 : 6'd6;
        else
            exp_len = 6'd0;
    endfunction
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr >= 12'h024 && paddr <= 12'h3FC |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property (psel && penable && paddr <= `LCCA_A_EXTCFG && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped access");
    a_err_reads_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_start_busy: assert property (psel && penable && pwrite && paddr == `LCCA_A_CTRL && pwdata[0] && !busy |=> busy)
        else $error("start did not raise busy");
    a_done_pulse: assert property (done_q |=> !done_q) else $error("done longer than one cycle");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:21] !busy) else $error("busy too long");
    a_cycle_count: assert property ($fell(busy) && exp_len(opc_q) != 6'd0 |-> run_len_q == exp_len(opc_q))
        else $error("wrong cycle count");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !busy && !done_q && prdata == 32'h0000_0000)
        else $error("outputs active after reset");
endmodule // lcca_checker
bind lcca_core lcca_checker lcca_checker_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .done_q(done_q));
`default_nettype wire

// File: tb/lcca_mem_model.sv
// Shadow of the register file and external data memory
`timescale 1ns/1ps
`default_nettype none
module lcca_mem_model;
    // ----------------------------------------
    // Storage images
    // ----------------------------------------
    // register file and external memory images
    logic [7:0] rf [0:255];
    logic [7:0] xm [0:255];
endmodule // lcca_mem_model
`default_nettype wire

// File: tb/logic_compare_call_alu_bench.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "lcca_map.vh"
module logic_compare_call_alu_bench;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, q;
    logic [7:0] d, s, f, r, op;
    logic [15:0] x;
    wire [31:0] prdata;
    wire pready, pslverr, busy, done_q;
    int mismatches = 0, samples_checked = 0;
    lcca_core lcca_core_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
        .done_q(done_q));
    lcca_mem_model lcca_mem_model_inst ();
    initial forever #25 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Tasks and reference
    // ----------------------------------------
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dv);
        int n;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dv;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        for (n = 0; pready !== 1'b1 && n < 16; n++)
            @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (n == 16)
        begin
            mismatches++;
            complete_run;
        end
    endtask
    task run(input logic [7:0] o, a, b);
        int n;
        apb(1, `LCCA_A_OPC, o);
        apb(1, `LCCA_A_OPA, a);
        apb(1, `LCCA_A_OPB, b);
        apb(1, `LCCA_A_CTRL, 1);
        q = 1;
        for (n = 0; q[0] === 1'b1 && n < 40; n++)
            apb(0, `LCCA_A_STATUS, 0);
        if (q[0] !== 1'b0)
        begin
            mismatches++;
            complete_run;
        end
    endtask
    task setrf(input logic [7:0] a, v);
        apb(1, `LCCA_A_RF_BASE + {2'b00, a, 2'b00}, v);
        lcca_mem_model_inst.rf[a] = v;
    endtask
    task chkrf(input logic [7:0] a, v, input string nm);
        apb(0, `LCCA_A_RF_BASE + {2'b00, a, 2'b00}, 0);
        chk(nm, q & 32'h0000_00FF, v);
    endtask
    task chkfl(input logic [7:0] v);
        apb(0, `LCCA_A_FLAGS, 0);
        chk("flags", q[7:0], v);
    endtask
    // Result in the high byte, flags in the low byte
    function automatic logic [15:0] alu(input logic [7:0] o, dv, sv, fv);
        logic [8:0] t;
        logic h, v;
        t = (o[7:4] == 4'hA) ? {1'b0, dv} - {1'b0, sv} : {1'b0, dv} + {1'b0, sv};
        if (o[7:4] == 4'h5)
            t = {fv[7], dv & sv};
        h = ({1'b0, dv[3:0]} + {1'b0, sv[3:0]}) > 5'h0F;
        v = (o[7:4] == 4'hA) ? (dv[7] != sv[7]) && (t[7] != dv[7]) : (o[7:4] == 4'h0) && (dv[7] == sv[7]) && (t[7] != dv[7]);
        alu = {(o[7:4] == 4'hA) ? dv : t[7:0], t[8], t[7:0] == 8'h00, t[7], v, (o[7:4] == 4'h0) ? {1'b0, h} : fv[3:2], 2'b00};
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(60782));
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        chkfl(8'h00);
        apb(0, 12'h040, 0);
        chk("unmapped", {q[30:0], e}, 32'h0000_0001);
        apb(1, `LCCA_A_EXTCFG, 32'h0000_0100);
        // Pointers for the indirect source and destination forms
        setrf(8'h1D, 8'h1C);
        setrf(8'h1E, 8'h13);
        for (int i = 0; i < 30; i++)
        begin
            op = {(i % 3 == 0) ? 4'h5 : (i % 3 == 1) ? 4'h0 : 4'hA, 4'(2 + i / 5)};
            d = (i < 3) ? 8'hFF : 8'($urandom);
            s = (i < 3) ? 8'h01 : 8'($urandom);
            f = 8'($urandom) & 8'hFC;
            setrf(8'h13, d);
            setrf(8'h1C, s);
            apb(1, `LCCA_A_FLAGS, f);
            x = alu(op, d, s, f);
            // Every form lands on 13H; full forms name the source as a working register
            case (op[3:0])
                4'h2: run(op, 8'h3C, 8'h00);
                4'h3: run(op, 8'h3D, 8'h00);
                4'h4: run(op, 8'hEC, 8'h13);
                4'h5: run(op, 8'hED, 8'h13);
                4'h6: run(op, 8'h13, s);
                default: run(op, 8'h1E, s);
            endcase
            chkrf(8'h13, x[15:8], "dst");
            chkrf(8'h1C, lcca_mem_model_inst.rf[8'h1C], "src");
            chkfl(x[7:0]);
        end
        $display("two-operand test done");
        // Undecoded opcode ends at once, flags the error and writes nothing
        run(8'h58, 8'h13, 8'h00);
        apb(0, `LCCA_A_STATUS, 0);
        chk("illegal", q[1:0], 2'b10);
        chkrf(8'h13, x[15:8], "illegal dst");
        $display("illegal test done");
        for (int i = 0; i < 4; i++)
        begin
            op = (i < 2) ? 8'(8'h60 + i) : 8'(8'hAE + i);
            d = 8'($urandom);
            f = 8'($urandom) & 8'hFC;
            setrf(8'h30, d);
            setrf(8'h31, 8'h30);
            apb(1, `LCCA_A_FLAGS, f);
            run(op, op[0] ? 8'h31 : 8'h30, 0);
            r = (i < 2) ? ~d : 8'h00;
            chkrf(8'h30, r, "one-operand");
            chkfl((i < 2) ? {f[7], r == 8'h00, r[7], 1'b0, f[3:2], 2'b00} : f);
        end
        $display("one-operand test done");
        for (int i = 0; i < 2; i++)
        begin
            f = 8'($urandom) & 8'hFC;
            apb(1, `LCCA_A_FLAGS, f);
            run(8'hEF, 0, 0);
            chkfl(f ^ 8'h80);
        end
        $display("carry test done");
        apb(1, `LCCA_A_EXTCFG, 32'h0000_0101);
        setrf(8'hFE, 8'h00);
        setrf(8'hFF, 8'h42);
        apb(1, `LCCA_A_PCIN, 32'h0000_1A47);
        run(8'hD6, 8'h35, 8'h21);
        chkrf(8'hFF, 8'h40, "sp low");
        chkrf(8'hFE, 8'h00, "sp high");
        // Expected pushes kept in the far-side memory image
        lcca_mem_model_inst.xm[8'h40] = 8'h1A;
        lcca_mem_model_inst.xm[8'h41] = 8'h4A;
        apb(0, `LCCA_A_XM_BASE + 12'h100, 0);
        chk("xm high", q, {24'h00_0000, lcca_mem_model_inst.xm[8'h40]});
        apb(0, `LCCA_A_XM_BASE + 12'h104, 0);
        chk("xm low", q, {24'h00_0000, lcca_mem_model_inst.xm[8'h41]});
        apb(0, `LCCA_A_PC, 0);
        chk("pc", q[15:0], 16'h3521);
        chkfl(f ^ 8'h80);
        // Pair and pointed-to pair both hold the target
        apb(1, `LCCA_A_EXTCFG, 32'h0000_0100);
        setrf(8'hFF, 8'h72);
        setrf(8'hA4, 8'h35);
        setrf(8'hA5, 8'h21);
        setrf(8'h35, 8'h35);
        setrf(8'h36, 8'h21);
        run(8'hD4, 8'hA4, 0);
        chkrf(8'hFF, 8'h70, "sp");
        chkrf(8'h70, 8'h1A, "push high");
        chkrf(8'h71, 8'h49, "push low");
        apb(0, `LCCA_A_PC, 0);
        chk("pc", q[15:0], 16'h3521);
        $display("call test done");
        complete_run;
    end
endmodule // logic_compare_call_alu_bench
`default_nettype wire
